// file: common/hsi_pkg.sv
// Shared constants and types of the handheld switch interlock
package hsi_pkg;

  // Clock and documented times
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned ENTRY_WIN_S   = 10;
  localparam int unsigned HOLD_S        = 1;
  localparam int unsigned ADDR_OFF_S    = 10;
  // Indicator times, chosen for a visible yellow start and audible beeps
  localparam int unsigned SHOW_MS       = 300;
  localparam int unsigned BEEP_MS       = 60;
  localparam int unsigned FLASH_MS      = 250;

  // Cycle counts derived from the times (all well above one cycle)
  localparam int unsigned ENTRY_WIN_CYC = CLK_HZ * ENTRY_WIN_S;
  localparam int unsigned HOLD_CYC      = CLK_HZ * HOLD_S;
  localparam int unsigned ADDR_OFF_CYC  = CLK_HZ * ADDR_OFF_S;
  localparam int unsigned SHOW_CYC      = (CLK_HZ / 1000) * SHOW_MS;
  localparam int unsigned BEEP_CYC      = (CLK_HZ / 1000) * BEEP_MS;
  localparam int unsigned FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;

  // Widths
  localparam int unsigned MOT_W   = 8;
  localparam int unsigned AUX_W   = 8;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned KEY_W   = 4;
  localparam int unsigned CODE_N  = 4;
  localparam int unsigned RA_W    = 4;

  // Register map
  localparam logic [RA_W-1:0] REG_CFG    = 4'h0;
  localparam logic [RA_W-1:0] REG_STATUS = 4'h4;
  localparam logic [31:0]     CFG_RST    = 32'h0000_0000;
  localparam int unsigned     CFG_CODE_EN = 0;
  localparam int unsigned     CFG_MODE_LO = 1;
  localparam int unsigned     CFG_CODE_LO = 8;
  localparam int unsigned     CFG_AUXM_LO = 16;

  // Centre pushbutton roles
  localparam logic [1:0] CTR_ALARM = 2'h0;
  localparam logic [1:0] CTR_RESET = 2'h1;
  localparam logic [1:0] CTR_BOTH  = 2'h2;

  typedef enum logic [2:0] {
    S_OFF, S_START, S_CODE, S_RUN, S_DIAG, S_LOCK, S_ADDR_OFF
  } hsi_state_t;

  typedef struct packed {
    logic [MOT_W-1:0] motion;
    logic [AUX_W-1:0] aux;
    logic             alarm;
    logic             reset;
    logic             mag_lift;
    logic             mag_drop;
    logic             vac_lift;
    logic             vac_rel;
    logic             grab_close;
    logic             grab_open;
    logic             rot_cw;
    logic             rot_ccw;
  } hsi_cmd_t;

  typedef struct packed {
    logic lift;
    logic drop;
    logic vac;
    logic vrel;
    logic close;
    logic open;
    logic cw;
    logic ccw;
  } hsi_btn_t;

endpackage

// file: design/hsi_top.sv
// Switch supervision and function sequencing of the handheld controller
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module hsi_top
  import hsi_pkg::*;
#(
  parameter int unsigned P_ENTRY_WIN_CYC = ENTRY_WIN_CYC,
  parameter int unsigned P_HOLD_CYC      = HOLD_CYC,
  parameter int unsigned P_ADDR_OFF_CYC  = ADDR_OFF_CYC,
  parameter int unsigned P_SHOW_CYC      = SHOW_CYC,
  parameter int unsigned P_BEEP_CYC      = BEEP_CYC,
  parameter int unsigned P_FLASH_CYC     = FLASH_CYC
) (
  // Clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  // Operator switches
  input  wire logic             POWER_ON,
  input  wire logic             ENABLING_BAR,
  input  wire logic [MOT_W-1:0] MOTION_SW,
  input  wire logic [AUX_W-1:0] AUX_SW,
  input  wire logic             CENTRE_BTN,
  input  wire hsi_btn_t         BUTTONS,
  input  wire logic [KEY_W-1:0] CODE_KEYS,
  input  wire logic [ADDR_W-1:0] ADDR_SEL,
  // Battery and transmitter status
  input  wire logic             BATT_LOW,
  input  wire logic             TX_ACTIVE,
  // Register port
  input  wire logic [RA_W-1:0]  REG_ADDR,
  input  wire logic [31:0]      REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [31:0]      REG_RDATA,
  // Toward the encoder and transmitter
  output logic                  TX_EN,
  output logic      [ADDR_W-1:0] TX_ADDR,
  output hsi_cmd_t              COMMANDS,
  // Indication
  output logic                  LED_RED,
  output logic                  LED_GREEN,
  output logic                  BEEP,
  output logic                  DIAG_MODE
);

  if (P_SHOW_CYC < 3 * P_BEEP_CYC || P_BEEP_CYC == 0 || P_FLASH_CYC == 0 ||
      P_HOLD_CYC == 0 || P_ENTRY_WIN_CYC == 0 || P_ADDR_OFF_CYC == 0) begin : g_chk
    $error("hsi_top: timing parameters out of range");
  end

  hsi_state_t        st_q;
  logic [31:0]       tmr_q;
  logic [31:0]       cfg_q;
  logic [ADDR_W-1:0] addr_q;
  logic [KEY_W-1:0]  key_prev_q;
  logic [1:0]        code_pos_q;
  logic [MOT_W-1:0]  mot_prev_q;
  logic [MOT_W-1:0]  mot_ok_q;
  logic [1:0]        hold_done;
  logic [31:0]       flash_cnt_q;
  logic              flash_ph_q;
  hsi_cmd_t          cmd_d;
  hsi_cmd_t          cmd_q;
  logic              run;
  logic              key_rise;
  logic [1:0]        key_idx;
  logic [1:0]        key_want;
  logic              code_en;
  logic [1:0]        ctr_mode;
  logic [AUX_W-1:0]  aux_bar_mask;

  assign run          = (st_q == S_RUN);
  assign code_en      = cfg_q[CFG_CODE_EN];
  assign ctr_mode     = cfg_q[CFG_MODE_LO +: 2];
  assign aux_bar_mask = cfg_q[CFG_AUXM_LO +: AUX_W];
  assign key_want     = cfg_q[CFG_CODE_LO + 2 * code_pos_q +: 2];

  // Register port: configuration write, read data one cycle later
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= CFG_RST;
    end else if (REG_WR && REG_ADDR == REG_CFG) begin
      cfg_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_CFG:    REG_RDATA <= cfg_q;
        REG_STATUS: REG_RDATA <= {22'h00_0000, addr_q, 1'b0, 3'(st_q), TX_EN, DIAG_MODE};
        default:    REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  // Entry code keys: the lowest newly pressed key counts
  always_comb begin
    key_rise = 1'b0;
    key_idx  = 2'h0;
    for (int i = KEY_W - 1; i >= 0; i--) begin
      if (CODE_KEYS[i] && !key_prev_q[i]) begin
        key_rise = 1'b1;
        key_idx  = 2'(i);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      key_prev_q <= '0;
      code_pos_q <= 2'h0;
    end else begin
      key_prev_q <= CODE_KEYS;
      if (st_q != S_CODE) begin
        code_pos_q <= 2'h0;
      end else if (key_rise) begin
        // A wrong key restarts the sequence rather than locking out at once
        code_pos_q <= (key_idx == key_want) ? code_pos_q + 2'h1 : 2'h0;
      end
    end
  end

  // Power-up sequencing and address supervision
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q  <= S_OFF;
      tmr_q <= 32'h0000_0000;
    end else if (!POWER_ON) begin
      st_q  <= S_OFF;
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
      case (st_q)
        S_OFF: begin
          tmr_q <= 32'h0000_0000;
          st_q  <= ENABLING_BAR ? S_DIAG : S_START;
        end
        S_START: begin
          if (tmr_q >= P_SHOW_CYC - 1) begin
            tmr_q <= 32'h0000_0000;
            st_q  <= code_en ? S_CODE : S_RUN;
          end
        end
        S_CODE: begin
          if (key_rise && key_idx == key_want && code_pos_q == 2'(CODE_N - 1)) begin
            tmr_q <= 32'h0000_0000;
            st_q  <= S_RUN;
          end else if (tmr_q >= P_ENTRY_WIN_CYC - 1) begin
            st_q <= S_LOCK;
          end
        end
        S_RUN: begin
          if (ADDR_SEL != addr_q) begin
            tmr_q <= 32'h0000_0000;
            st_q  <= S_ADDR_OFF;
          end
        end
        S_ADDR_OFF: begin
          if (tmr_q >= P_ADDR_OFF_CYC - 1) begin
            tmr_q <= 32'h0000_0000;
            st_q  <= S_START;
          end
        end
        S_DIAG:  st_q <= S_DIAG;
        S_LOCK:  st_q <= S_LOCK;
        default: st_q <= S_OFF;
      endcase
    end
  end

  // Address is taken at each start, so a restart picks up the new one
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q <= '0;
    end else if (st_q == S_START || st_q == S_OFF) begin
      addr_q <= ADDR_SEL;
    end
  end

  // Motion arming: a switch counts only if it left centre with the bar down
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mot_prev_q <= '0;
      mot_ok_q   <= '0;
    end else begin
      mot_prev_q <= MOTION_SW;
      for (int i = 0; i < MOT_W; i++) begin
        mot_ok_q[i] <= run && ENABLING_BAR && MOTION_SW[i] &&
                       (mot_ok_q[i] || !mot_prev_q[i]);
      end
    end
  end

  // One-second hold timers for lift and vacuum
  for (genvar g = 0; g < 2; g++) begin : g_hold
    logic [31:0] cnt_q;
    logic        btn;
    assign btn          = (g == 0) ? BUTTONS.lift : BUTTONS.vac;
    assign hold_done[g] = (cnt_q >= P_HOLD_CYC);
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        cnt_q <= 32'h0000_0000;
      end else if (!btn || !run) begin
        cnt_q <= 32'h0000_0000;
      end else if (!hold_done[g]) begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

  // Command assembly; everything is silent outside normal running
  always_comb begin
    cmd_d            = '0;
    cmd_d.motion     = mot_ok_q;
    cmd_d.aux        = AUX_SW & (~aux_bar_mask | {AUX_W{ENABLING_BAR}});
    cmd_d.alarm      = CENTRE_BTN && (ctr_mode == CTR_ALARM || ctr_mode == CTR_BOTH);
    cmd_d.reset      = CENTRE_BTN && (ctr_mode == CTR_RESET || ctr_mode == CTR_BOTH);
    cmd_d.mag_lift   = BUTTONS.lift && hold_done[0];
    cmd_d.mag_drop   = BUTTONS.lift && hold_done[0] && BUTTONS.drop;
    cmd_d.vac_lift   = BUTTONS.vac && hold_done[1];
    cmd_d.vac_rel    = BUTTONS.vac && hold_done[1] && BUTTONS.vrel;
    cmd_d.grab_close = BUTTONS.close && !BUTTONS.open;
    cmd_d.grab_open  = BUTTONS.close && BUTTONS.open;
    cmd_d.rot_cw     = BUTTONS.cw && !BUTTONS.ccw;
    cmd_d.rot_ccw    = BUTTONS.ccw && !BUTTONS.cw;
    if (!run) begin
      cmd_d = '0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q     <= '0;
      TX_EN     <= 1'b0;
      DIAG_MODE <= 1'b0;
    end else begin
      cmd_q     <= cmd_d;
      TX_EN     <= run;
      DIAG_MODE <= (st_q == S_DIAG);
    end
  end

  assign COMMANDS = cmd_q;
  assign TX_ADDR  = addr_q;

  // Flash rhythm divider
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_ph_q  <= 1'b0;
    end else if (flash_cnt_q >= P_FLASH_CYC - 1) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_ph_q  <= !flash_ph_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  // Indicator: both colours together read as yellow
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
      BEEP      <= 1'b0;
    end else begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
      BEEP      <= 1'b0;
      if (st_q == S_START) begin
        LED_RED   <= 1'b1;
        LED_GREEN <= 1'b1;
        BEEP      <= (tmr_q < P_BEEP_CYC) ||
                     (tmr_q >= 2 * P_BEEP_CYC && tmr_q < 3 * P_BEEP_CYC);
      end else if (run && BATT_LOW) begin
        LED_RED <= flash_ph_q;
        BEEP    <= flash_ph_q;
      end else if (run && TX_ACTIVE) begin
        LED_GREEN <= flash_ph_q;
      end
    end
  end

  a_bar_at_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    st_q == S_OFF && POWER_ON && ENABLING_BAR |=> st_q == S_DIAG ##1 DIAG_MODE)
    else $error("bar held at switch-on did not enter diagnostics");

  a_diag_no_tx: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    st_q == S_DIAG |=> !TX_EN && cmd_q == '0)
    else $error("diagnostic mode transmits");

  a_start_yellow: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    st_q == S_START && POWER_ON && tmr_q == 0 |=> LED_RED && LED_GREEN && BEEP)
    else $error("switch-on indication missing");

  a_low_batt_red: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    run && BATT_LOW |=> !LED_GREEN)
    else $error("green shown with low battery");

  a_motion_bar: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !ENABLING_BAR |=> ##1 cmd_q.motion == '0)
    else $error("motion without enabling bar");

  a_motion_late_bar: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    MOTION_SW[0] && !ENABLING_BAR ##1 MOTION_SW[0] |=> ##1 !cmd_q.motion[0])
    else $error("bar pressed after switch moved gave motion");

  a_code_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    st_q == S_CODE |=> cmd_q == '0 && !TX_EN)
    else $error("command issued during entry code");

  a_lift_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(cmd_q.mag_lift) |-> $past(BUTTONS.lift, 2) && $past(g_hold[0].cnt_q) >= P_HOLD_CYC)
    else $error("magnet lift before one second hold");

  a_drop_alone: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !BUTTONS.lift |=> !cmd_q.mag_drop)
    else $error("drop without lift held");

  a_alarm_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    run && ctr_mode == CTR_BOTH && CENTRE_BTN |=> cmd_q.alarm && cmd_q.reset)
    else $error("combined alarm and reset not together");

  a_rot_centre: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !BUTTONS.cw && !BUTTONS.ccw |=> !cmd_q.rot_cw && !cmd_q.rot_ccw)
    else $error("rotation commanded at centre");

  a_addr_restart: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    run && POWER_ON && ADDR_SEL != addr_q |=> st_q == S_ADDR_OFF ##1 !TX_EN)
    else $error("address change did not switch off");

  a_lock_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    st_q == S_LOCK |=> !TX_EN && cmd_q == '0)
    else $error("locked out controller transmits");

  a_vac_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !hold_done[1] |=> !cmd_q.vac_lift && !cmd_q.vac_rel)
    else $error("vacuum command before one second hold");

  a_grab_close: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !BUTTONS.close |=> !cmd_q.grab_close && !cmd_q.grab_open)
    else $error("grab commanded without close held");

  a_aux_free: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    run && aux_bar_mask == '0 |=> cmd_q.aux == $past(AUX_SW))
    else $error("auxiliary command not passed without bar");

  a_tx_green: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    run && TX_ACTIVE && !BATT_LOW |=> !LED_RED)
    else $error("red shown while transmitting with good battery");

endmodule // hsi_top

// file: testbench/hsi_rx_model.sv
// Receiver and decoder model at the machine end of the radio link
`timescale 1ns/10ps
module hsi_rx_model
  import hsi_pkg::*;
#(
  parameter logic [ADDR_W-1:0] MY_ADDR = 4'h2
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Link from the controller
  input  wire logic              tx_en,
  input  wire logic [ADDR_W-1:0] tx_addr,
  input  wire hsi_cmd_t          cmds,
  // Machine side
  output logic                   contactor_q,
  output logic                   horn_q
);
  wire logic mine = tx_en && (tx_addr == MY_ADDR);

  // Contactor drops with the link, so every restart needs a fresh reset command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      contactor_q <= 1'b0;
    end else if (!mine) begin
      contactor_q <= 1'b0;
    end else if (cmds.reset) begin
      contactor_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      horn_q <= 1'b0;
    end else begin
      horn_q <= mine && cmds.alarm;
    end
  end
endmodule  // hsi_rx_model

// file: testbench/hsi_top_tb_top.sv
// Self-checking bench for the handheld switch interlock
`timescale 1ns/10ps
module hsi_top_tb_top
  import hsi_pkg::*;
;
  // Short counts keep the run brief; the long waits below derive from them
  localparam int unsigned ENT = 200;
  localparam int unsigned HLD = 20;
  localparam int unsigned AOF = 50;
  localparam int unsigned SHW = 30;
  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic              power_on = 1'b0;
  logic              bar      = 1'b0;
  logic              centre   = 1'b0;
  logic              batt_low = 1'b0;
  logic              tx_act   = 1'b0;
  logic              reg_wr   = 1'b0;
  logic              reg_rd   = 1'b0;
  logic [MOT_W-1:0]  motion   = 8'h00;
  logic [AUX_W-1:0]  aux      = 8'h00;
  hsi_btn_t          btn      = 8'h00;
  logic [KEY_W-1:0]  keys     = 4'h0;
  logic [ADDR_W-1:0] addr_sel = 4'h2;
  logic [RA_W-1:0]   reg_addr = 4'h0;
  logic [31:0]       reg_wdat = 32'h0000_0000;
  logic [31:0]       reg_rdat, v;
  logic              tx_en, led_red, led_green, beep, diag, contactor, horn;
  logic [ADDR_W-1:0] tx_addr;
  hsi_cmd_t          cmds;
  logic [7:0]        p, s;
  logic [7:0]        gb [7] = '{8'h08, 8'h0C, 8'h04, 8'h02, 8'h01, 8'h03, 8'h00};
  logic [3:0]        ge [7] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h1, 4'h0, 4'h0};
  int                ks [6] = '{2, 1, 2, 0, 3, 1};
  int                miscompares = 0;
  int                num_checks = 0;
  int                nr, ng, nb;

  always #10 core_clk = ~core_clk;

  hsi_top #(
    .P_ENTRY_WIN_CYC(ENT), .P_HOLD_CYC(HLD), .P_ADDR_OFF_CYC(AOF),
    .P_SHOW_CYC(SHW), .P_BEEP_CYC(5), .P_FLASH_CYC(4)
  ) dut_u (
    .CORE_CLK(core_clk), .RST_N(rst_n), .POWER_ON(power_on), .ENABLING_BAR(bar),
    .MOTION_SW(motion), .AUX_SW(aux), .CENTRE_BTN(centre), .BUTTONS(btn),
    .CODE_KEYS(keys), .ADDR_SEL(addr_sel), .BATT_LOW(batt_low), .TX_ACTIVE(tx_act),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdat), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdat), .TX_EN(tx_en), .TX_ADDR(tx_addr), .COMMANDS(cmds),
    .LED_RED(led_red), .LED_GREEN(led_green), .BEEP(beep), .DIAG_MODE(diag)
  );

  hsi_rx_model #(.MY_ADDR(4'h2)) rx_u (
    .clk(core_clk), .rst_n(rst_n), .tx_en(tx_en), .tx_addr(tx_addr), .cmds(cmds),
    .contactor_q(contactor), .horn_q(horn)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic note(input string t);
    $display("test %s done at %0t", t, $time);
  endtask

  // Checks sit on falling edges, away from the edges that launch changes
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [RA_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdat <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [RA_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdat;
  endtask

  task automatic pwr(input logic on, input logic b);
    @(posedge core_clk);
    power_on <= on;
    bar <= b;
  endtask

  task automatic sw(input logic [7:0] m, input logic b, input logic [7:0] a,
                    input logic c, input hsi_btn_t bt, input int n);
    @(posedge core_clk);
    motion <= m;
    bar <= b;
    aux <= a;
    centre <= c;
    btn <= bt;
    tick(n);
  endtask

  task automatic key(input int i);
    @(posedge core_clk);
    keys <= 4'h1 << i;
    tick(2);
    @(posedge core_clk);
    keys <= 4'h0;
    tick(2);
  endtask

  task automatic wait_tx(input int lim);
    for (int k = 0; k < lim && tx_en !== 1'b1; k++) begin
      tick(1);
    end
    chk(tx_en, 1'b1);
  endtask

  // Counts rising edges of the indicator outputs over n cycles
  task automatic rises(input int n);
    logic pr, pg, pb;
    nr = 0;
    ng = 0;
    nb = 0;
    pr = led_red;
    pg = led_green;
    pb = beep;
    repeat (n) begin
      tick(1);
      nr += int'(led_red && !pr);
      ng += int'(led_green && !pg);
      nb += int'(beep && !pb);
      pr = led_red;
      pg = led_green;
      pb = beep;
    end
  endtask

  function automatic logic [1:0] pair(input int k);
    return k ? {cmds.vac_lift, cmds.vac_rel} : {cmds.mag_lift, cmds.mag_drop};
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end

  initial begin
    tick(10);
    chk({tx_en, diag, led_red, led_green, beep, cmds}, 32'h0);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(REG_CFG, v);
    chk(v, CFG_RST);
    wr(REG_CFG, 32'h0000_0004);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    wr(4'h8, 32'hFFFF_FFFF);
    rd(REG_CFG, v);
    chk(v, 32'h0000_0004);
    rd(REG_STATUS, v);
    chk(v, 32'h0000_0080);
    rd(4'hC, v);
    chk(v, 32'h0000_0000);
    note("registers");
    pwr(1'b1, 1'b1);
    tick(4);
    chk(diag, 1'b1);
    tick(SHW + 10);
    chk({tx_en, cmds}, 32'h0);
    pwr(1'b0, 1'b0);
    tick(3);
    chk(diag, 1'b0);
    note("diagnostic");
    pwr(1'b1, 1'b0);
    rises(3);
    v = 32'(nb);
    chk({led_red, led_green, beep}, 3'h7);
    rises(SHW + 5);
    chk(v + 32'(nb), 32'h2);
    wait_tx(10);
    chk(tx_addr, 4'h2);
    @(posedge core_clk);
    tx_act <= 1'b1;
    tick(3);
    rises(16);
    chk(ng >= 2 && nr == 0, 1'b1);
    @(posedge core_clk);
    batt_low <= 1'b1;
    tick(3);
    rises(16);
    chk(nr >= 2 && ng == 0, 1'b1);
    @(posedge core_clk);
    batt_low <= 1'b0;
    tx_act <= 1'b0;
    note("indication");
    sw(8'h01, 1'b0, 8'h5A, 1'b0, 8'h00, 4);
    chk({cmds.motion, cmds.aux}, 16'h005A);
    sw(8'h01, 1'b1, 8'h5A, 1'b0, 8'h00, 4);
    chk(cmds.motion, 8'h00);
    sw(8'h00, 1'b1, 8'h5A, 1'b0, 8'h00, 2);
    sw(8'h81, 1'b1, 8'h5A, 1'b0, 8'h00, 4);
    chk(cmds.motion, 8'h81);
    sw(8'h81, 1'b0, 8'h5A, 1'b0, 8'h00, 4);
    chk(cmds.motion, 8'h00);
    sw(8'h81, 1'b1, 8'h5A, 1'b0, 8'h00, 4);
    chk(cmds.motion, 8'h00);
    wr(REG_CFG, 32'h0001_0004);
    sw(8'h00, 1'b0, 8'h5B, 1'b0, 8'h00, 4);
    chk(cmds.aux, 8'h5A);
    sw(8'h00, 1'b1, 8'h5B, 1'b0, 8'h00, 4);
    chk(cmds.aux, 8'h5B);
    note("motion");
    for (int r = 0; r < 3; r++) begin
      wr(REG_CFG, 32'(r) << 1);
      sw(8'h00, 1'b0, 8'h00, 1'b1, 8'h00, 4);
      chk({cmds.alarm, cmds.reset}, {r != 1, r != 0});
      chk({horn, contactor}, {r != 1, r != 0});
      sw(8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 2);
    end
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'h20 : 8'h80;
      s = k ? 8'h10 : 8'h40;
      sw(8'h00, 1'b0, 8'h00, 1'b0, s, 5);
      chk(pair(k), 2'h0);
      sw(8'h00, 1'b0, 8'h00, 1'b0, p, HLD / 2);
      chk(pair(k), 2'h0);
      tick(HLD);
      chk(pair(k), 2'h2);
      sw(8'h00, 1'b0, 8'h00, 1'b0, p | s, 3);
      chk(pair(k), 2'h3);
      sw(8'h00, 1'b0, 8'h00, 1'b0, s, 3);
      chk(pair(k), 2'h0);
      sw(8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 2);
    end
    foreach (gb[i]) begin
      sw(8'h00, 1'b0, 8'h00, 1'b0, gb[i], 3);
      chk({cmds.grab_close, cmds.grab_open, cmds.rot_cw, cmds.rot_ccw}, ge[i]);
    end
    note("functions");
    sw(8'h00, 1'b0, 8'h5A, 1'b0, 8'h00, 4);
    @(posedge core_clk);
    addr_sel <= 4'h3;
    tick(4);
    chk({tx_en, cmds}, 32'h0);
    tick(AOF - 10);
    chk(tx_en, 1'b0);
    wait_tx(SHW + 20);
    chk({tx_addr, cmds.aux}, 12'h35A);
    chk(contactor, 1'b0);
    note("address");
    pwr(1'b0, 1'b0);
    tick(3);
    chk({tx_en, cmds}, 32'h0);
    wr(REG_CFG, 32'h0000_7201);
    pwr(1'b1, 1'b0);
    tick(SHW + 5);
    rd(REG_STATUS, v);
    chk(v[4:2], 3'h2);
    chk(cmds, 32'h0);
    foreach (ks[i]) begin
      key(ks[i]);
    end
    wait_tx(10);
    chk(cmds.aux, 8'h5A);
    pwr(1'b0, 1'b0);
    tick(3);
    pwr(1'b1, 1'b0);
    tick(ENT + SHW + 20);
    rd(REG_STATUS, v);
    chk(v[4:2], 3'h5);
    chk({tx_en, cmds}, 32'h0);
    pwr(1'b0, 1'b0);
    note("entry code");
    close_out;
  end
endmodule  // hsi_top_tb_top
